// [startup_reset_sequencer.sv]
`timescale 1ns/1ps
module startup_reset_sequencer #(
   parameter int POR_CYC   = startup_pkg::POR_TYP_CYC,
   parameter int REQ_CYC   = startup_pkg::CLK_REQ_CYC,
   parameter int SLEEP_CYC = startup_pkg::SLEEP_MIN_CYC,
   parameter int GAP_CYC   = startup_pkg::SLOW_GAP_CYC,
   parameter int DIV_CYC   = startup_pkg::SLOW_DIV_CYC
) (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        reset_n,
   // pins
   input  wire logic                        ext_rst_n,
   input  wire logic                        core_supply_ok,
   input  wire logic                        low_power_oscillator,
   // startup status
   output startup_pkg::startup_status_t     status,
   // low-power clock selection
   output startup_pkg::slow_clk_status_t    slow_clk_status
);
   localparam int W = startup_pkg::CNT_W;
   // minimum hold scaled with the chosen hold, so shortened runs still check
   localparam int POR_MIN = (POR_CYC * startup_pkg::POR_MIN_US) /
                            startup_pkg::POR_TYP_US;

   logic [2:0]   meta_ff;
   logic [2:0]   sync_ff;
   logic         ext_asserted;
   logic         supply_good;
   logic [W-1:0] por_cnt_ff;
   logic         por_active_ff;
   logic [W-1:0] seq_cnt_ff;
   startup_pkg::seq_state_t state_ff;
   startup_pkg::seq_state_t nxt_state;
   startup_pkg::startup_status_t status_ff;

   assign ext_asserted = ~sync_ff[0];
   assign supply_good  = sync_ff[1];
   assign status       = status_ff;

   ////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers for the pins
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= 3'h0;
         sync_ff <= 3'h0;
      end else begin
         meta_ff <= {low_power_oscillator, core_supply_ok, ext_rst_n};
         sync_ff <= meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power-on reset: held for POR_CYC after the supply is good
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         por_cnt_ff    <= '0;
         por_active_ff <= 1'b1;
      end else if (!supply_good) begin
         por_cnt_ff    <= '0;
         por_active_ff <= 1'b1;                              // [RULE3]
      end else if (por_cnt_ff == W'(POR_CYC)) begin
         por_active_ff <= 1'b0;                              // [RULE3]
      end else begin
         por_cnt_ff    <= por_cnt_ff + W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequence counter, restarted at every global reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         seq_cnt_ff <= '0;
      end else if (!status_ff.global_rst_n) begin
         seq_cnt_ff <= '0;                                   // [RULE8]
      end else if (seq_cnt_ff != W'(SLEEP_CYC)) begin
         seq_cnt_ff <= seq_cnt_ff + W'(1);                   // [RULE8]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // startup sequence
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         startup_pkg::ST_RESET: begin
            if (status_ff.global_rst_n) begin
               nxt_state = startup_pkg::ST_WAIT;
            end
         end
         startup_pkg::ST_WAIT: begin
            if (seq_cnt_ff == W'(REQ_CYC)) begin
               nxt_state = startup_pkg::ST_SLEEP;            // [RULE4]
            end
         end
         startup_pkg::ST_SLEEP: begin
            if (seq_cnt_ff == W'(SLEEP_CYC)) begin
               nxt_state = startup_pkg::ST_RUN;              // [RULE5]
            end
         end
         startup_pkg::ST_RUN: begin
            nxt_state = startup_pkg::ST_RUN;
         end
         default: begin
            nxt_state = startup_pkg::ST_RESET;
         end
      endcase
      if (!status_ff.global_rst_n) begin
         nxt_state = startup_pkg::ST_RESET;                  // [RULE1]
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= startup_pkg::ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_ff <= '{global_rst_n: 1'b0, clk_req: 1'b0,
                        sleeping: 1'b1, boot_run: 1'b0};
      end else begin
         // either source holds the chip; the later release wins
         status_ff.global_rst_n <= ~(ext_asserted | por_active_ff); // [RULE2]
         status_ff.clk_req      <= (nxt_state == startup_pkg::ST_SLEEP) ||
                                   (nxt_state == startup_pkg::ST_RUN); // [RULE4]
         status_ff.sleeping     <= (nxt_state != startup_pkg::ST_RUN);  // [RULE5]
         status_ff.boot_run     <= (nxt_state == startup_pkg::ST_RUN);  // [RULE1]
      end
   end

   slow_clk_monitor #(
      .GAP_CYC (GAP_CYC),
      .DIV_CYC (DIV_CYC)
   ) u_slow (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .slow_level (sync_ff[2]),
      .slow_out   (slow_clk_status)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_reset_hold: assert property ( // [RULE2]
      @(posedge core_clk) disable iff (!reset_n)
      (ext_asserted || por_active_ff) |=> !status_ff.global_rst_n)
      else $error("global reset released while a source holds it");

   a_reset_free: assert property ( // [RULE2]
      @(posedge core_clk) disable iff (!reset_n)
      (!ext_asserted && !por_active_ff) |=> status_ff.global_rst_n)
      else $error("global reset held with both sources released");

   a_por_min_hold: assert property ( // [RULE3]
      @(posedge core_clk) disable iff (!reset_n)
      $fell(por_active_ff) |-> por_cnt_ff >= W'(POR_MIN))
      else $error("power-on reset released too early");

   a_clk_req_time: assert property ( // [RULE4]
      @(posedge core_clk) disable iff (!reset_n)
      $rose(status_ff.clk_req) |-> $past(seq_cnt_ff) == W'(REQ_CYC))
      else $error("clock request at wrong time");

   a_sleep_min: assert property ( // [RULE5]
      @(posedge core_clk) disable iff (!reset_n)
      $fell(status_ff.sleeping) |-> $past(seq_cnt_ff) == W'(SLEEP_CYC))
      else $error("sleep ended before minimum period");

   a_count_restart: assert property ( // [RULE8]
      @(posedge core_clk) disable iff (!reset_n)
      !status_ff.global_rst_n |=> seq_cnt_ff == '0 ##1 !status_ff.clk_req)
      else $error("sequence counter not restarted by reset");

   a_boot_held: assert property ( // [RULE1]
      @(posedge core_clk) disable iff (!reset_n)
      !status_ff.global_rst_n |=> !status_ff.boot_run && status_ff.sleeping)
      else $error("boot ran while reset held");
endmodule : startup_reset_sequencer

// [startup_pkg.sv]
// Behaviour
// [RULE1] Startup and boot are held off while the reset pin is low, or start from power-up under the power-on reset.
// [RULE2] Global reset stays active while either the reset pin or the power-on reset is asserted and releases with the later one.
// [RULE3] The power-on reset holds typically 3 ms after the core supply passes 0.8V, and never less than 1.5 ms.
// [RULE4] About 120 us after reset release the reference-clock request output is asserted.
// [RULE5] After reset release the chip stays in sleep for at least 4.2 ms before startup continues.
// [RULE6] The outside party has its reference and low-power clocks running before the 4.2 ms sleep ends.
// [RULE7] With no clock on the low-power clock input, its absence is detected and the internal low-power clock is used.
// [RULE8] The request delay and the sleep period are counted from global reset release on the always-running clock.
package startup_pkg;
   localparam int CLK_MHZ       = 200;
   localparam int POR_TYP_US    = 3000;
   localparam int POR_MIN_US    = 1500;
   localparam int CLK_REQ_US    = 120;
   localparam int SLEEP_MIN_US  = 4200;
   // low-power clock nominal period 30.52 us; declared absent after 100 us
   localparam int SLOW_GAP_US   = 100;
   localparam int SLOW_INT_HZ   = 32768;
   localparam int POR_TYP_CYC   = POR_TYP_US * CLK_MHZ;
   localparam int POR_MIN_CYC   = POR_MIN_US * CLK_MHZ;
   localparam int CLK_REQ_CYC   = CLK_REQ_US * CLK_MHZ;
   localparam int SLEEP_MIN_CYC = SLEEP_MIN_US * CLK_MHZ;
   localparam int SLOW_GAP_CYC  = SLOW_GAP_US * CLK_MHZ;
   localparam int SLOW_DIV_CYC  = (CLK_MHZ * 1000000) / SLOW_INT_HZ;
   localparam int CNT_W         = 20;
   localparam int SLOW_CNT_W    = 16;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_WAIT  = 2'b01,
      ST_SLEEP = 2'b10,
      ST_RUN   = 2'b11
   } seq_state_t;

   typedef struct packed {
      logic global_rst_n;
      logic clk_req;
      logic sleeping;
      logic boot_run;
   } startup_status_t;

   typedef struct packed {
      logic use_internal;
      logic tick;
   } slow_clk_status_t;
endpackage : startup_pkg

// [lpo_monitor.sv]
`timescale 1ns/1ps
module slow_clk_monitor #(
   parameter int GAP_CYC = startup_pkg::SLOW_GAP_CYC,
   parameter int DIV_CYC = startup_pkg::SLOW_DIV_CYC
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     reset_n,
   // synchronised low-power clock level
   input  wire logic                     slow_level,
   // selected low-power clock
   output startup_pkg::slow_clk_status_t slow_out
);
   localparam int W = startup_pkg::SLOW_CNT_W;

   logic         last_ff;
   logic [W-1:0] gap_cnt_ff;
   logic [W-1:0] div_cnt_ff;
   logic         absent_ff;
   logic         ext_edge;
   logic         int_tick;
   startup_pkg::slow_clk_status_t out_ff;

   assign ext_edge = slow_level & ~last_ff;
   assign int_tick = (div_cnt_ff == W'(DIV_CYC - 1));
   assign slow_out = out_ff;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_ff <= 1'b0;
      end else begin
         last_ff <= slow_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // absence detector: no rising edge within the gap window
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_cnt_ff <= '0;
         absent_ff  <= 1'b1;
      end else if (ext_edge) begin
         gap_cnt_ff <= '0;
         absent_ff  <= 1'b0;
      end else if (gap_cnt_ff == W'(GAP_CYC)) begin
         absent_ff  <= 1'b1;                                 // [RULE7]
      end else begin
         gap_cnt_ff <= gap_cnt_ff + W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // internal low-power clock as an enable pulse
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_ff <= '0;
      end else if (int_tick) begin
         div_cnt_ff <= '0;
      end else begin
         div_cnt_ff <= div_cnt_ff + W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_ff <= '{use_internal: 1'b1, tick: 1'b0};
      end else begin
         out_ff.use_internal <= absent_ff;                   // [RULE7]
         out_ff.tick         <= absent_ff ? int_tick : ext_edge;
      end
   end

   a_slow_fallback: assert property ( // [RULE7]
      @(posedge core_clk) disable iff (!reset_n)
      (gap_cnt_ff == W'(GAP_CYC)) && !ext_edge |=> ##1 out_ff.use_internal)
      else $error("internal low-power clock not chosen");

   a_slow_present: assert property ( // [RULE7]
      @(posedge core_clk) disable iff (!reset_n)
      ext_edge |=> ##1 !out_ff.use_internal)
      else $error("external low-power clock ignored");
endmodule : slow_clk_monitor

// [host_model.sv]
`timescale 1ns/1ps
module host_model (
   // clock
   input  wire logic       core_clk,
   // bench controls
   input  wire logic       hold_rst,
   input  wire logic       supply_on,
   input  wire logic       osc_en,
   input  wire logic [3:0] osc_half,
   // pins
   output wire logic       ext_rst_n,
   output wire logic       core_supply_ok,
   output logic            low_power_oscillator
);
   logic [3:0] ph_ff;

   assign ext_rst_n      = ~hold_rst;
   assign core_supply_ok = supply_on;

   // clock stands low while the host has it switched off
   always_ff @(posedge core_clk) begin
      if (!osc_en) begin
         ph_ff                <= 4'h0;
         low_power_oscillator <= 1'b0;
      end else if (ph_ff >= osc_half - 4'h1) begin
         ph_ff                <= 4'h0;
         low_power_oscillator <= ~low_power_oscillator;
      end else begin
         ph_ff <= ph_ff + 4'h1;
      end
   end
endmodule : host_model

// [startup_reset_sequencer_test.sv]
`timescale 1ns/1ps
module startup_reset_sequencer_test;
   localparam int POR = 200;
   localparam int REQ = 50;
   localparam int SLP = 300;
   localparam int GAP = 40;
   localparam int DIV = 10;
   logic                          core_clk;
   logic                          reset_n;
   logic                          hold_rst;
   logic                          supply_on;
   logic                          osc_en;
   logic [3:0]                    osc_half;
   wire logic                     ext_rst_n;
   wire logic                     supply_ok;
   wire logic                     osc_pin;
   startup_pkg::startup_status_t  status;
   startup_pkg::slow_clk_status_t slow_clk_status;
   wire logic [5:0]               obs = {status, slow_clk_status};
   int                            fails;
   int                            comparisons;
   int                            n;
   int                            m;
   int                            h;
   int                            cnt;

   host_model u_host (.core_clk(core_clk), .hold_rst(hold_rst),
      .supply_on(supply_on), .osc_en(osc_en), .osc_half(osc_half),
      .ext_rst_n(ext_rst_n), .core_supply_ok(supply_ok),
      .low_power_oscillator(osc_pin));
   startup_reset_sequencer #(.POR_CYC(POR), .REQ_CYC(REQ), .SLEEP_CYC(SLP),
      .GAP_CYC(GAP), .DIV_CYC(DIV)) u_dut (.core_clk(core_clk),
      .reset_n(reset_n), .ext_rst_n(ext_rst_n), .core_supply_ok(supply_ok),
      .low_power_oscillator(osc_pin), .status(status),
      .slow_clk_status(slow_clk_status));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input int lo, input int hi,
                      input int g);
      comparisons++;
      if (g < lo || g > hi) begin
         fails++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask : chk
   task automatic chkb(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask : chkb
   // edges until the watched output bit settles at v
   task automatic wait_obs(input int b, input logic v, output int k);
      k = 0;
      do begin
         @(posedge core_clk);
         #1;
         k++;
      end while (obs[b] !== v && k < 4000);
   endtask : wait_obs
   // sequence after global reset has just risen
   task automatic run_seq();
      wait_obs(4, 1'b1, n);
      chk("clk_req delay", REQ + 1, REQ + 3, n);
      chkb("sleeping at req", 1'b1, obs[3]);
      wait_obs(3, 1'b0, m);
      chk("sleep length", SLP + 1, SLP + 3, n + m);
      chkb("boot_run", 1'b1, obs[2]);
      chkb("clk_req held", 1'b1, obs[4]);
   endtask : run_seq
   task automatic test_done();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      $display("[FAIL] watchdog expected done seen hang");
      test_done();
   end
   initial begin
      {reset_n, hold_rst, supply_on, osc_en} = 4'h0;
      osc_half = 4'h4;
      n = $urandom(53);
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      supply_on <= 1'b1;
      wait_obs(5, 1'b1, n);
      chk("por release", POR + 3, POR + 5, n);
      run_seq();
      $display("test por_start done");
      @(posedge core_clk);
      hold_rst <= 1'b1;
      wait_obs(5, 1'b0, n);
      chk("pin reset fall", 2, 4, n);
      repeat (2) @(posedge core_clk);
      #1;
      chkb("req cleared", 1'b0, obs[4]);
      chkb("sleep restart", 1'b1, obs[3]);
      chkb("boot held", 1'b0, obs[2]);
      repeat (20 + $urandom % 30) @(posedge core_clk);
      hold_rst <= 1'b0;
      wait_obs(5, 1'b1, n);
      chk("pin reset rise", 2, 4, n);
      run_seq();
      $display("test pin_reset done");
      @(posedge core_clk);
      hold_rst  <= 1'b1;
      supply_on <= 1'b0;
      repeat (10) @(posedge core_clk);
      supply_on <= 1'b1;
      repeat (10 + $urandom % 90) @(posedge core_clk);
      hold_rst <= 1'b0;
      wait_obs(5, 1'b1, m);
      chk("later source wins", POR - 97, POR + 4, m);
      run_seq();
      $display("test both_sources done");
      chkb("internal at start", 1'b1, obs[1]);
      wait_obs(0, 1'b1, n);
      wait_obs(0, 1'b1, n);
      chk("internal tick period", DIV, DIV, n);
      h = 3 + $urandom % 6;
      @(posedge core_clk);
      osc_half <= 4'(h);
      osc_en   <= 1'b1;
      wait_obs(1, 1'b0, n);
      chk("external selected", 1, 4 * h + 6, n);
      cnt = 0;
      repeat (40 * h) begin
         @(posedge core_clk);
         #1;
         if (obs[0] === 1'b1) cnt++;
      end
      chk("external ticks", 19, 21, cnt);
      @(posedge core_clk);
      osc_en <= 1'b0;
      wait_obs(1, 1'b1, n);
      chk("absence detect", GAP - 2 * h, GAP + 6, n);
      $display("test low_power_clock done");
      test_done();
   end
endmodule : startup_reset_sequencer_test
